//--- common/adcc_map.vh
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCC_OFS_RES_LO 4'h0
`define ADCC_OFS_RES_HI 4'h1
`define ADCC_OFS_LLIM_LO 4'h2
`define ADCC_OFS_LLIM_HI 4'h3
`define ADCC_OFS_HLIM_LO 4'h4
`define ADCC_OFS_HLIM_HI 4'h5
`define ADCC_OFS_CTRL 4'h6
`define ADCC_OFS_SRC_CLK 4'h7
`define ADCC_OFS_REF_GAIN 4'h8
`define ADCC_OFS_TRIG_CMP 4'h9
`define ADCC_OFS_DELAY 4'hA
`define ADCC_OFS_REF_EN 4'hB
`define ADCC_OFS_PIN_SEL 4'hC

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ADCC_CTRL_START 7
`define ADCC_CTRL_BUSY 6
`define ADCC_CTRL_ENABLE 5
`define ADCC_CTRL_FORMAT 4

// ----------------------------------------
// Trigger and compare register fields
// ----------------------------------------
`define ADCC_TRIG_SRC 7
`define ADCC_TRIG_DLY_EN 6
`define ADCC_TRIG_DUTY_SEL 5
`define ADCC_TRIG_CMP_HI 4
`define ADCC_TRIG_CMP_LO 3

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define ADCC_SRC_CLK_MASK 8'hE7
`define ADCC_REF_GAIN_MASK 8'h9F
`define ADCC_TRIG_CMP_MASK 8'hFB
`define ADCC_REF_EN_MASK 8'h01
`define ADCC_RST_REG 8'h00
`define ADCC_RST_WORD 12'h000

// ----------------------------------------
// Source and compare codes
// ----------------------------------------
`define ADCC_SRC_EXTERNAL 3'h0
`define ADCC_CMP_INSIDE 2'h0
`define ADCC_CMP_BELOW 2'h1
`define ADCC_CMP_ABOVE 2'h2
`define ADCC_CMP_OUTSIDE 2'h3

`endif

//--- hw/adcc_top.v
`timescale 1ns/1ns
`include "adcc_map.vh"

// Functional notes
// - Result byte placement follows format bit
// - Unused result bits read zero
// - Result pair read-only, latest conversion
// - Limit pairs use same format placement
// - Compare result against limits, raise event
// - Start on start bit high-low sequence
// - Busy set on start, cleared at end
// - Enable zero switches converter off
// - Disable leaves result and limits unchanged
// - One source routed by two select fields
// - Internal sources converted at 12 bits
// - Delayed path inserts programmed delay
// - Delay register used only on delay path
// - Analog pin drops its digital function
// - Analog pin drops its pull-up
// - Control bit enables bandgap reference
// - All registers eight bits wide
// - Control register resets to zero
// - Internal select codes, external disconnected
// - Clock select divides by 1 to 128
// - Compare condition codes select window test
// - Delay counts system clocks from flag rise
module adcc_top (
  input wire core_clk, // System clock, 125 MHz
  input wire reset, // Synchronous reset, active high
  input wire [3:0] reg_addr, // Register offset
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata, // Read data, cycle after strobe
  input wire pwm_period_flag, // PWM period match flag
  input wire [2:0] pwm_duty_flag, // PWM duty match flags
  input wire conv_done_in, // Converter core end of conversion
  input wire [11:0] conv_data_in, // Converter core result
  input wire [7:0] gpio_pullup_req, // Pull-up requests of pins
  output reg conv_power_en, // Converter core powered
  output reg conv_start, // One-cycle conversion start
  output reg conv_clk_en, // Conversion clock enable pulse
  output reg [2:0] internal_source_sel, // Internal source select
  output reg [3:0] external_channel_sel, // External channel select
  output reg ext_channel_connect, // External channel switch closed
  output reg [7:0] ref_gain_cfg, // Reference and gain settings
  output reg bandgap_en, // Bandgap reference enable
  output reg [7:0] pin_analog_mode, // Pin taken from digital use
  output reg [7:0] pin_pullup_en, // Pull-up connected
  output reg compare_event // One-cycle compare hit
);

  // ----------------------------------------
  // Format helpers
  // ----------------------------------------
  function [7:0] fmt_hi;
    input [11:0] v;
    input f;
    begin
      if (f) begin
        fmt_hi = {4'h0, v[11:8]};
      end else begin
        fmt_hi = v[11:4];
      end
    end
  endfunction

  function [7:0] fmt_lo;
    input [11:0] v;
    input f;
    begin
      if (f) begin
        fmt_lo = v[7:0];
      end else begin
        fmt_lo = {v[3:0], 4'h0};
      end
    end
  endfunction

  // Replace one byte of a 12-bit word as the format places it
  function [11:0] put_byte;
    input [11:0] v;
    input [7:0] b;
    input hi;
    input f;
    begin
      if (hi && f) begin
        put_byte = {b[3:0], v[7:0]};
      end else if (hi) begin
        put_byte = {b, v[3:0]};
      end else if (f) begin
        put_byte = {v[11:8], b};
      end else begin
        put_byte = {v[11:4], b[7:4]};
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [11:0] result_q;
  reg [11:0] low_limit_q;
  reg [11:0] high_limit_q;
  reg start_bit_q;
  reg busy_q;
  reg enable_q;
  reg format_q;
  reg [3:0] chan_q;
  reg [7:0] src_clk_q;
  reg [7:0] ref_gain_q;
  reg [7:0] trig_cmp_q;
  reg [7:0] delay_q;
  reg [7:0] ref_en_q;
  reg [7:0] pin_sel_q;

  wire wr_ctrl;
  wire start_seq;
  wire delay_fire;
  wire done_pulse;

  assign wr_ctrl = reg_wr && (reg_addr == `ADCC_OFS_CTRL);
  // High then low on the start bit
  assign start_seq = wr_ctrl && start_bit_q &&
    !reg_wdata[`ADCC_CTRL_START];

  always @(posedge core_clk) begin
    if (reset) begin
      start_bit_q <= 1'b0;
      enable_q <= 1'b0;
      format_q <= 1'b0;
      chan_q <= 4'h0;
      src_clk_q <= `ADCC_RST_REG;
      ref_gain_q <= `ADCC_RST_REG;
      trig_cmp_q <= `ADCC_RST_REG;
      delay_q <= `ADCC_RST_REG;
      ref_en_q <= `ADCC_RST_REG;
      pin_sel_q <= `ADCC_RST_REG;
      low_limit_q <= `ADCC_RST_WORD;
      high_limit_q <= `ADCC_RST_WORD;
    end else if (reg_wr) begin
      if (reg_addr == `ADCC_OFS_CTRL) begin
        start_bit_q <= reg_wdata[`ADCC_CTRL_START];
        enable_q <= reg_wdata[`ADCC_CTRL_ENABLE];
        format_q <= reg_wdata[`ADCC_CTRL_FORMAT];
        chan_q <= reg_wdata[3:0];
      end else if (reg_addr == `ADCC_OFS_LLIM_LO) begin
        low_limit_q <= put_byte(low_limit_q, reg_wdata, 1'b0,
          format_q);
      end else if (reg_addr == `ADCC_OFS_LLIM_HI) begin
        low_limit_q <= put_byte(low_limit_q, reg_wdata, 1'b1,
          format_q);
      end else if (reg_addr == `ADCC_OFS_HLIM_LO) begin
        high_limit_q <= put_byte(high_limit_q, reg_wdata, 1'b0,
          format_q);
      end else if (reg_addr == `ADCC_OFS_HLIM_HI) begin
        high_limit_q <= put_byte(high_limit_q, reg_wdata, 1'b1,
          format_q);
      end else if (reg_addr == `ADCC_OFS_SRC_CLK) begin
        src_clk_q <= reg_wdata & `ADCC_SRC_CLK_MASK;
      end else if (reg_addr == `ADCC_OFS_REF_GAIN) begin
        ref_gain_q <= reg_wdata & `ADCC_REF_GAIN_MASK;
      end else if (reg_addr == `ADCC_OFS_TRIG_CMP) begin
        trig_cmp_q <= reg_wdata & `ADCC_TRIG_CMP_MASK;
      end else if (reg_addr == `ADCC_OFS_DELAY) begin
        delay_q <= reg_wdata;
      end else if (reg_addr == `ADCC_OFS_REF_EN) begin
        ref_en_q <= reg_wdata & `ADCC_REF_EN_MASK;
      end else if (reg_addr == `ADCC_OFS_PIN_SEL) begin
        pin_sel_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // End of conversion synchroniser
  // ----------------------------------------
  reg done_s1_q;
  reg done_s2_q;
  reg done_s3_q;

  always @(posedge core_clk) begin
    if (reset) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= conv_done_in;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  // Data from the core is held stable while done is high
  assign done_pulse = done_s2_q && !done_s3_q && busy_q;

  // ----------------------------------------
  // Delayed PWM trigger
  // ----------------------------------------
  reg pwm_sel_q;
  reg [7:0] dly_cnt_q;
  reg dly_run_q;
  wire pwm_sel_d;
  wire dly_path;

  assign pwm_sel_d = trig_cmp_q[`ADCC_TRIG_DUTY_SEL] ?
    pwm_duty_flag[(trig_cmp_q[1:0] == 2'h3) ? 2'h2 : trig_cmp_q[1:0]] :
    pwm_period_flag;
  assign dly_path = trig_cmp_q[`ADCC_TRIG_SRC] &&
    trig_cmp_q[`ADCC_TRIG_DLY_EN];
  assign delay_fire = dly_run_q && (dly_cnt_q >= delay_q);

  always @(posedge core_clk) begin
    if (reset) begin
      pwm_sel_q <= 1'b0;
      dly_cnt_q <= 8'h00;
      dly_run_q <= 1'b0;
    end else begin
      pwm_sel_q <= pwm_sel_d;
      if (!dly_path || !enable_q) begin
        dly_run_q <= 1'b0;
        dly_cnt_q <= 8'h00;
      end else if (pwm_sel_d && !pwm_sel_q && !dly_run_q) begin
        // Counting starts on the flag rise
        dly_run_q <= 1'b1;
        dly_cnt_q <= 8'h01;
      end else if (delay_fire) begin
        dly_run_q <= 1'b0;
        dly_cnt_q <= 8'h00;
      end else if (dly_run_q) begin
        dly_cnt_q <= dly_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  wire go;
  assign go = enable_q && !busy_q &&
    (trig_cmp_q[`ADCC_TRIG_SRC] ? delay_fire : start_seq);

  always @(posedge core_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      result_q <= `ADCC_RST_WORD;
      conv_start <= 1'b0;
    end else begin
      conv_start <= go;
      if (!enable_q) begin
        // Power-down abandons a conversion, keeps the result
        busy_q <= 1'b0;
      end else if (go) begin
        busy_q <= 1'b1;
      end else if (done_pulse) begin
        busy_q <= 1'b0;
        result_q <= conv_data_in;
      end
    end
  end

  // ----------------------------------------
  // Boundary compare
  // ----------------------------------------
  wire le_low;
  wire ge_high;
  reg cmp_hit;

  assign le_low = conv_data_in <= low_limit_q;
  assign ge_high = conv_data_in >= high_limit_q;

  always @* begin
    case ({trig_cmp_q[`ADCC_TRIG_CMP_HI], trig_cmp_q[`ADCC_TRIG_CMP_LO]})
      `ADCC_CMP_INSIDE: cmp_hit = !le_low && !ge_high;
      `ADCC_CMP_BELOW: cmp_hit = le_low;
      `ADCC_CMP_ABOVE: cmp_hit = ge_high;
      default: cmp_hit = le_low || ge_high;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      compare_event <= 1'b0;
    end else begin
      compare_event <= done_pulse && enable_q && cmp_hit;
    end
  end

  // ----------------------------------------
  // Conversion clock divider
  // ----------------------------------------
  reg [6:0] div_cnt_q;
  wire [6:0] div_mask;

  assign div_mask = (7'h7F >> (3'h7 - src_clk_q[2:0]));

  always @(posedge core_clk) begin
    if (reset) begin
      div_cnt_q <= 7'h00;
      conv_clk_en <= 1'b0;
    end else if (!enable_q) begin
      div_cnt_q <= 7'h00;
      conv_clk_en <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
      conv_clk_en <= ((div_cnt_q & div_mask) == 7'h00);
    end
  end

  // ----------------------------------------
  // Analog routing and pin control
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      conv_power_en <= 1'b0;
      internal_source_sel <= 3'h0;
      external_channel_sel <= 4'h0;
      ext_channel_connect <= 1'b0;
      ref_gain_cfg <= 8'h00;
      bandgap_en <= 1'b0;
      pin_analog_mode <= 8'h00;
      pin_pullup_en <= 8'h00;
    end else begin
      conv_power_en <= enable_q;
      internal_source_sel <= src_clk_q[7:5];
      external_channel_sel <= chan_q;
      ext_channel_connect <= enable_q &&
        (src_clk_q[7:5] == `ADCC_SRC_EXTERNAL);
      ref_gain_cfg <= ref_gain_q;
      bandgap_en <= ref_en_q[0];
      pin_analog_mode <= pin_sel_q;
      pin_pullup_en <= gpio_pullup_req & ~pin_sel_q;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  reg [7:0] rd_d;

  always @* begin
    if (reg_addr == `ADCC_OFS_RES_LO) begin
      rd_d = fmt_lo(result_q, format_q);
    end else if (reg_addr == `ADCC_OFS_RES_HI) begin
      rd_d = fmt_hi(result_q, format_q);
    end else if (reg_addr == `ADCC_OFS_LLIM_LO) begin
      rd_d = fmt_lo(low_limit_q, format_q);
    end else if (reg_addr == `ADCC_OFS_LLIM_HI) begin
      rd_d = fmt_hi(low_limit_q, format_q);
    end else if (reg_addr == `ADCC_OFS_HLIM_LO) begin
      rd_d = fmt_lo(high_limit_q, format_q);
    end else if (reg_addr == `ADCC_OFS_HLIM_HI) begin
      rd_d = fmt_hi(high_limit_q, format_q);
    end else if (reg_addr == `ADCC_OFS_CTRL) begin
      rd_d = {start_bit_q, busy_q, enable_q, format_q, chan_q};
    end else if (reg_addr == `ADCC_OFS_SRC_CLK) begin
      rd_d = src_clk_q;
    end else if (reg_addr == `ADCC_OFS_REF_GAIN) begin
      rd_d = ref_gain_q;
    end else if (reg_addr == `ADCC_OFS_TRIG_CMP) begin
      rd_d = trig_cmp_q;
    end else if (reg_addr == `ADCC_OFS_DELAY) begin
      rd_d = delay_q;
    end else if (reg_addr == `ADCC_OFS_REF_EN) begin
      rd_d = ref_en_q;
    end else if (reg_addr == `ADCC_OFS_PIN_SEL) begin
      rd_d = pin_sel_q;
    end else begin
      rd_d = 8'h00;
    end
  end

  // Data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

//--- tb/adcc_core_model.sv
`timescale 1ns/1ns
module adcc_core_model #(
  parameter LAT = 6 // Start to end of conversion
) (
  input wire core_clk, // Clock
  input wire conv_power_en, // Core powered
  input wire conv_start, // Start pulse
  input wire [11:0] sample_value, // Value to convert
  output reg conv_done_in, // End of conversion
  output reg [11:0] conv_data_in // Result
);
  integer cnt = 0;
  initial conv_done_in = 1'b0;
  initial conv_data_in = 12'h000;
  // Data toggles outside its window so a stale latch is caught
  always @(posedge core_clk) begin
    cnt <= !conv_power_en ? 0 : conv_start ? LAT + 4 : cnt > 0 ? cnt - 1 : 0;
    conv_done_in <= conv_power_en && cnt >= 2 && cnt <= 5;
    conv_data_in <= (cnt >= 1 && cnt <= 6) ? sample_value : ~conv_data_in;
  end
endmodule

//--- tb/adcc_top_assertions.sv
`timescale 1ns/1ns
module adcc_top_assertions (
  input wire core_clk, // Clock
  input wire reset, // Reset
  input wire [3:0] reg_addr, // Offset
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_rdata, // Read data
  input wire [7:0] gpio_pullup_req, // Pull-up requests
  input wire conv_power_en, // Core power
  input wire conv_start, // Start pulse
  input wire conv_clk_en, // Clock pulse
  input wire [2:0] internal_source_sel, // Source
  input wire ext_channel_connect, // Ext switch
  input wire bandgap_en, // Bandgap
  input wire [7:0] pin_analog_mode, // Analog pins
  input wire [7:0] pin_pullup_en, // Pull-ups
  input wire compare_event // Compare hit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  pullup_mask_a: assert property (!$past(reset) && $stable(pin_analog_mode)
    |-> pin_pullup_en == ($past(gpio_pullup_req) & ~pin_analog_mode))
    else $error("pull-up left on analog pin");
  ext_connect_a: assert property (ext_channel_connect
    |-> internal_source_sel == 3'h0) else $error("external switch wrong");
  start_space_a: assert property (conv_start |=> !conv_start [*4])
    else $error("start repeated during conversion");
  clk_power_a: assert property (conv_clk_en
    |-> conv_power_en || $past(conv_power_en)) else $error("clock while off");
  event_pulse_a: assert property (compare_event |=> !compare_event)
    else $error("compare event too long");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  rdata_unmap_a: assert property (reg_rd && reg_addr > 4'hC
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  bandgap_copy_a: assert property (reg_wr && reg_addr == 4'hB
    |=> ##1 bandgap_en == $past(reg_wdata[0], 2)) else $error("bandgap wrong");
endmodule
bind adcc_top adcc_top_assertions adcc_top_assertions_i (.core_clk, .reset,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .gpio_pullup_req,
  .conv_power_en, .conv_start, .conv_clk_en, .internal_source_sel,
  .ext_channel_connect, .bandgap_en, .pin_analog_mode, .pin_pullup_en,
  .compare_event);

//--- tb/adcc_top_tb_top.sv
`timescale 1ns/1ns
`define CK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("ERROR %s exp %h got %h", nm, e, g); \
  end \
end
module adcc_top_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg pwm_period_flag = 1'b0;
  reg [2:0] pwm_duty_flag = 3'h0;
  reg [7:0] gpio_pullup_req = 8'h00;
  reg [11:0] sample_value = 12'h000;
  wire [7:0] reg_rdata, ref_gain_cfg, pin_analog_mode, pin_pullup_en;
  wire conv_done_in, conv_power_en, conv_start, conv_clk_en;
  wire ext_channel_connect, bandgap_en, compare_event;
  wire [11:0] conv_data_in;
  wire [2:0] internal_source_sel;
  wire [3:0] external_channel_sel;
  integer n_fail = 0;
  integer num_checks = 0;
  integer n_start = 0, n_evt = 0, n_clk = 0, i, k, e, ns, ne;
  reg [7:0] exp_q[$];
  reg [7:0] ex, c, m, r, dl;
  reg [1:0] t;
  reg rd_pend = 1'b0;
  reg f;
  reg [11:0] d;
  reg [15:0] pr, ll, hl;
  reg [3:0] ma [0:3] = '{4'h7, 4'h8, 4'h9, 4'hB};
  reg [7:0] mk [0:3] = '{8'hE7, 8'h9F, 8'hFB, 8'h01};
  always #4 core_clk = ~core_clk;
  adcc_top adcc_top_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_period_flag(pwm_period_flag),
    .pwm_duty_flag(pwm_duty_flag), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in), .gpio_pullup_req(gpio_pullup_req),
    .conv_power_en(conv_power_en), .conv_start(conv_start),
    .conv_clk_en(conv_clk_en), .internal_source_sel(internal_source_sel),
    .external_channel_sel(external_channel_sel),
    .ext_channel_connect(ext_channel_connect), .ref_gain_cfg(ref_gain_cfg),
    .bandgap_en(bandgap_en), .pin_analog_mode(pin_analog_mode),
    .pin_pullup_en(pin_pullup_en), .compare_event(compare_event));
  adcc_core_model adcc_core_model_i (.core_clk(core_clk),
    .conv_power_en(conv_power_en), .conv_start(conv_start),
    .sample_value(sample_value), .conv_done_in(conv_done_in),
    .conv_data_in(conv_data_in));
  // ----------------------------------------
  // Monitors and bus tasks
  // ----------------------------------------
  always @(posedge core_clk) begin
    n_start <= n_start + conv_start;
    n_evt <= n_evt + compare_event;
    n_clk <= n_clk + conv_clk_en;
  end
  always @(negedge core_clk) begin
    if (rd_pend) begin
      ex = exp_q.pop_front();
      `CK("reg_rdata", ex, reg_rdata)
    end
    rd_pend <= reg_rd;
  end
  task op(input w, input rr, input [3:0] a, input [7:0] v);
    begin
      @(posedge core_clk);
      reg_wr <= w;
      reg_rd <= rr;
      reg_addr <= a;
      reg_wdata <= v;
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    op(1'b1, 1'b0, a, v);
  endtask
  task rd(input [3:0] a, input [7:0] v);
    begin
      exp_q.push_back(v);
      op(1'b0, 1'b1, a, 8'h00);
    end
  endtask
  task idle(input integer n);
    begin
      op(1'b0, 1'b0, 4'h0, 8'h00);
      repeat (n) @(posedge core_clk);
    end
  endtask
  function [15:0] place(input [11:0] v, input fm);
    place = fm ? {4'h0, v} : {v, 4'h0};
  endfunction
  function hit(input [1:0] cc, input [11:0] v);
    hit = cc == 2'h0 ? (v > 12'h400 && v < 12'hC00) : cc == 2'h1 ?
      v <= 12'h400 : cc == 2'h2 ? v >= 12'hC00 : v <= 12'h400 || v >= 12'hC00;
  endfunction
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
  initial begin
    void'($urandom(44293));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    for (i = 0; i < 16; i++) rd(i[3:0], 8'h00);
    idle(2);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      wr(ma[i], 8'hFF);
      rd(ma[i], mk[i]);
    end
    idle(2);
    `CK("bandgap_en", 1'b1, bandgap_en)
    `CK("ref_gain_cfg", 8'h9F, ref_gain_cfg)
    for (i = 0; i < 4; i++) wr(ma[i], 8'h00);
    wr(4'h0, 8'hFF);
    wr(4'h1, 8'hFF);
    wr(4'h2, 8'hFF);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'hF0);
    idle(2);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      f = i[2];
      d = i == 0 ? 12'h400 : i == 1 ? 12'h800 : i == 2 ? 12'hC00 : 12'($urandom);
      sample_value <= d;
      c = {3'h1, f, 4'h0};
      pr = place(d, f);
      ll = place(12'h400, f);
      hl = place(12'hC00, f);
      wr(4'h6, c);
      wr(4'h7, {i[2:0], 5'h00});
      wr(4'h9, {3'h0, i[1:0], 3'h0});
      wr(4'h3, ll[15:8]);
      wr(4'h2, ll[7:0]);
      wr(4'h5, hl[15:8]);
      wr(4'h4, hl[7:0]);
      ns = n_start;
      ne = n_evt;
      wr(4'h6, c | 8'h80);
      wr(4'h6, c);
      rd(4'h6, c | 8'h40);
      wr(4'h6, c | 8'h80);
      wr(4'h6, c);
      idle(0);
      for (k = 0; k < 60 && conv_done_in !== 1'b1; k++) @(posedge core_clk);
      idle(8);
      rd(4'h6, c);
      rd(4'h1, pr[15:8]);
      rd(4'h0, pr[7:0]);
      idle(2);
      `CK("start count", 1, n_start - ns)
      `CK("event count", hit(i[1:0], d), n_evt - ne)
    end
    $display("conversion test done");
    ns = n_start;
    wr(4'h6, 8'h10);
    wr(4'h6, 8'h90);
    wr(4'h6, 8'h10);
    idle(4);
    `CK("conv_power_en", 1'b0, conv_power_en)
    `CK("start count", 0, n_start - ns)
    rd(4'h1, pr[15:8]);
    rd(4'h0, pr[7:0]);
    rd(4'h5, hl[15:8]);
    wr(4'h6, 8'h20);
    $display("disable test done");
    for (i = 0; i < 8; i++) begin
      wr(4'h7, {i[2:0], 2'h0, i[2:0]});
      idle(2);
      k = n_clk;
      repeat (256) @(posedge core_clk);
      e = n_clk - k;
      `CK("clk_en", 1'b1, e >= (256 >> i) - 1 && e <= (256 >> i) + 1)
      `CK("source", i[2:0], internal_source_sel)
      `CK("ext_connect", i == 0, ext_channel_connect)
    end
    wr(4'h7, 8'h00);
    $display("source and clock test done");
    for (i = 0; i < 3; i++) begin
      dl = 8'h02 + 8'($urandom % 8'h1E);
      t = 2'($urandom);
      wr(4'hA, dl);
      // Random duty source; code 3 shares flag 2
      wr(4'h9, i == 0 ? 8'hC0 : i == 1 ? {6'h38, t} : 8'h40);
      idle(2);
      ns = n_start;
      if (i == 1) pwm_duty_flag <= 3'h1 << (t == 2'h3 ? 2'h2 : t);
      else pwm_period_flag <= 1'b1;
      for (e = 0; e < 60 && conv_start !== 1'b1; e++) @(posedge core_clk);
      if (i < 2) `CK("delay", 1'b1, e >= dl + 1 && e <= dl + 3)
      else `CK("start count", 0, n_start - ns)
      idle(20);
      pwm_period_flag <= 1'b0;
      pwm_duty_flag <= 3'h0;
    end
    $display("delay test done");
    m = 8'($urandom);
    r = 8'($urandom);
    gpio_pullup_req <= r;
    wr(4'hC, m);
    wr(4'h6, {4'h2, m[3:0]});
    idle(3);
    `CK("external_channel_sel", m[3:0], external_channel_sel)
    `CK("pin_analog_mode", m, pin_analog_mode)
    `CK("pin_pullup_en", r & ~m, pin_pullup_en)
    $display("pin test done");
    print_verdict;
  end
endmodule
